// ### hdl/purs_core.sv
// What this block does
// - Soon after supply crosses power_up_reset_threshold every macrocell register goes low.
// - After clearing each registered output shows the cleared value through its output polarity; combinatorial outputs show low.
// - A preload path forces any single register high or low for test sequencing.
// - Sixty-four bits of user signature stay readable whether secured or not.
// - One security fuse, once set, refuses pattern verify and blocks preload.
// - Setting the fuse takes effect at once, so the programmer sets it last.
// - Each macrocell is registered or combinatorial and active high or active low.
module purs_core #(
    parameter int NUM_CELLS    = purs_pkg::NUM_CELLS,
    parameter int RESET_CYCLES = purs_pkg::RESET_CYCLES
) (
    // Clock and supply-derived reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // Macrocell configuration and array results
    input  wire logic [NUM_CELLS-1:0]        cfg_registered,
    input  wire logic [NUM_CELLS-1:0]        cfg_active_low,
    input  wire logic [NUM_CELLS-1:0]        array_sum,
    // Programmer port
    input  wire logic [2:0]                  prog_cmd,
    input  wire logic [5:0]                  prog_addr,
    input  wire logic                        prog_data,
    // Outputs
    output logic [NUM_CELLS-1:0]             cell_out,
    output logic [NUM_CELLS-1:0]             cell_q,
    output logic                             reset_active,
    output logic                             secured,
    output logic                             prog_rdata,
    output logic                             prog_rvalid,
    output logic                             prog_refused
);

    // =========================================================================
    // Power-up reset pulse
    // =========================================================================
    logic [purs_pkg::RESET_CNT_BITS-1:0] rcnt_reg;
    logic                                reset_active_next;
    logic                                cnt_done;

    // The count stops at its last value, so the pulse falls once and stays low until rst.
    assign cnt_done          = (rcnt_reg == purs_pkg::RESET_CNT_BITS'(RESET_CYCLES - 1));
    assign reset_active_next = !cnt_done;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rcnt_reg     <= '0;
            reset_active <= 1'b1;
        end else begin
            if (!cnt_done) begin
                rcnt_reg <= rcnt_reg + 1'b1;
            end
            reset_active <= reset_active_next;
        end
    end

    // =========================================================================
    // Programmer command decode
    // =========================================================================
    logic cmd_preload;
    logic cmd_sig_wr;
    logic cmd_sig_rd;
    logic cmd_verify;
    logic cmd_secure;
    logic preload_ok;
    logic verify_ok;
    logic cell_sel_ok;
    logic [NUM_CELLS-1:0] sel_mask;
    logic                 cell_pick;

    assign cmd_preload = (prog_cmd == purs_pkg::PURS_CMD_PRELOAD);
    assign cmd_sig_wr  = (prog_cmd == purs_pkg::PURS_CMD_SIG_WRITE);
    assign cmd_sig_rd  = (prog_cmd == purs_pkg::PURS_CMD_SIG_READ);
    assign cmd_verify  = (prog_cmd == purs_pkg::PURS_CMD_VERIFY);
    assign cmd_secure  = (prog_cmd == purs_pkg::PURS_CMD_SECURE);
    assign cell_sel_ok = (int'(prog_addr) < NUM_CELLS);
    assign sel_mask    = cell_sel_ok ? (NUM_CELLS'(1) << prog_addr) : '0;
    // Verify reads the selected cell through the same one-hot mask as preload.
    assign cell_pick   = |(cell_q & sel_mask);
    // Preload and verify are gated by the fuse from the edge after it is set.
    assign preload_ok  = cmd_preload && !secured && cell_sel_ok;
    assign verify_ok   = cmd_verify && !secured && cell_sel_ok;

    // =========================================================================
    // Macrocell registers
    // =========================================================================
    logic [NUM_CELLS-1:0] cell_next;
    logic [NUM_CELLS-1:0] cell_load;

    // A preload overrides normal capture for the selected cell only.
    assign cell_load = preload_ok ? sel_mask : '0;
    assign cell_next = (cell_load & {NUM_CELLS{prog_data}}) | (~cell_load & array_sum);

    always_ff @(posedge clk_sys) begin
        if (rst || reset_active) begin
            cell_q <= '0;
        end else begin
            cell_q <= cell_next;
        end
    end

    // =========================================================================
    // Output polarity and mode
    // =========================================================================
    logic [NUM_CELLS-1:0] out_src;
    logic [NUM_CELLS-1:0] out_next;

    assign out_src  = (cfg_registered & cell_next) | (~cfg_registered & array_sum);
    assign out_next = out_src ^ cfg_active_low;

    always_ff @(posedge clk_sys) begin
        if (rst || reset_active) begin
            cell_out <= cfg_active_low & cfg_registered;
        end else begin
            cell_out <= out_next;
        end
    end

    // =========================================================================
    // Signature memory and security fuse
    // =========================================================================
    // Signature bits stay writable and readable whatever the fuse state.
    logic [purs_pkg::SIG_BITS-1:0] sig_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sig_reg      <= purs_pkg::SIG_RESET;
            secured      <= 1'b0;
            prog_rdata   <= 1'b0;
            prog_rvalid  <= 1'b0;
            prog_refused <= 1'b0;
        end else begin
            if (cmd_sig_wr) begin
                sig_reg[prog_addr] <= prog_data;
            end
            if (cmd_secure) begin
                secured <= 1'b1;
            end
            prog_rvalid  <= cmd_sig_rd || verify_ok;
            prog_rdata   <= cmd_sig_rd ? sig_reg[prog_addr] : (verify_ok && cell_pick);
            prog_refused <= (cmd_preload || cmd_verify) && secured;
        end
    end

    // =========================================================================
    // Checks
    // =========================================================================
    // Edges since rst went low, saturating at the pulse length; the pulse length
    // check leans on this count rather than on the counter that makes the pulse.
    logic [purs_pkg::RESET_CNT_BITS-1:0] since_rst_reg;
    logic                                since_sat;

    assign since_sat = (int'(since_rst_reg) >= RESET_CYCLES);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            since_rst_reg <= '0;
        end else if (!since_sat) begin
            since_rst_reg <= since_rst_reg + 1'b1;
        end
    end

    clear_after_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
        reset_active |=> (cell_q == '0))
        else $error("register not cleared during power-up reset");

    // During the pulse each registered pin shows the cleared register through its polarity, each combinatorial pin low.
    out_polarity_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(reset_active) |-> (cell_out == ($past(cfg_active_low) & $past(cfg_registered))))
        else $error("output level during reset ignores polarity");

    preload_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
        preload_ok && !reset_active |=>
            ((cell_q & $past(sel_mask)) == ($past(sel_mask) & {NUM_CELLS{$past(prog_data)}})))
        else $error("preload did not force the register");

    sig_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_sig_wr |=> (sig_reg[$past(prog_addr)] == $past(prog_data)))
        else $error("signature write did not land");

    sig_readable_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_sig_rd |=> prog_rvalid && (prog_rdata == $past(sig_reg[prog_addr])))
        else $error("signature read failed");

    secure_blocks_a: assert property (@(posedge clk_sys) disable iff (rst)
        secured && (cmd_verify || cmd_preload) |=> prog_refused && !prog_rvalid)
        else $error("secured device allowed verify or preload");

    unsecured_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
        !secured |=> !prog_refused)
        else $error("refusal raised while not secured");

    // The fuse has no clear but rst, so it stays set once taken.
    secure_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_secure |=> secured [*8])
        else $error("security fuse did not take effect at once");

    // Registered cells show the new register, combinatorial ones the array sum.
    comb_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
        !reset_active |=> (cell_out == (((cell_q & $past(cfg_registered))
            | ($past(array_sum) & ~$past(cfg_registered))) ^ $past(cfg_active_low))))
        else $error("output mode or polarity wrong");

    // The pulse must stand for exactly RESET_CYCLES edges after rst.
    reset_length_a: assert property (@(posedge clk_sys) disable iff (rst)
        reset_active == (int'(since_rst_reg) < RESET_CYCLES))
        else $error("power-up reset pulse has the wrong length");

    reset_release_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(reset_active) |-> (rcnt_reg == purs_pkg::RESET_CNT_BITS'(RESET_CYCLES - 1)))
        else $error("power-up reset released at the wrong count");

    // Scenarios worth seeing: preload, refusal, secured read, release, combinatorial output.
    preload_c: cover property (@(posedge clk_sys) disable iff (rst) preload_ok && !reset_active);
    refused_c: cover property (@(posedge clk_sys) disable iff (rst) prog_refused);
    sig_read_c: cover property (@(posedge clk_sys) disable iff (rst) secured && cmd_sig_rd);
    release_c: cover property (@(posedge clk_sys) disable iff (rst) $fell(reset_active));
    comb_out_c: cover property (@(posedge clk_sys) disable iff (rst)
        !reset_active && (cfg_registered != '1));

endmodule

// ### hdl/purs_pkg.sv
package purs_pkg;

    // =========================================================================
    // Sizes
    // =========================================================================
    localparam int NUM_CELLS       = 10;
    localparam int SIG_BITS        = 64;
    localparam int SIG_ADDR_BITS   = 6;

    // =========================================================================
    // Timing
    // =========================================================================
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int RESET_TIME_NS   = 1000;
    localparam int RESET_CYCLES    = (RESET_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int RESET_CNT_BITS  = 8;

    // =========================================================================
    // Reset values
    // =========================================================================
    localparam logic [9:0]  CELL_RESET = 10'h000;
    localparam logic [63:0] SIG_RESET  = 64'h0000000000000000;

    // =========================================================================
    // Programmer commands
    // =========================================================================
    typedef enum logic [2:0] {
        PURS_CMD_NOP       = 3'h0,
        PURS_CMD_PRELOAD   = 3'h1,
        PURS_CMD_SIG_WRITE = 3'h2,
        PURS_CMD_SIG_READ  = 3'h3,
        PURS_CMD_VERIFY    = 3'h4,
        PURS_CMD_SECURE    = 3'h5
    } purs_cmd_t;

endpackage

// ### verif/power_up_reset_security_test.sv
module power_up_reset_security_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RP = 4;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        prog_data = 1'b0;
    logic        pin_en = 1'b1;
    logic [9:0]  cfg_registered = 10'h3FF;
    logic [9:0]  cfg_active_low = 10'h000;
    logic [9:0]  pin_val = 10'h000;
    logic [2:0]  prog_cmd = 3'h0;
    logic [5:0]  prog_addr = 6'h00;
    logic [9:0]  array_sum, cell_out, cell_q;
    logic        reset_active, secured, prog_rdata, prog_rvalid, prog_refused;
    logic [63:0] sig;
    logic [2:0]  e;
    logic [2:0]  exp_q[$];
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    purs_core #(.NUM_CELLS(10), .RESET_CYCLES(RP)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .cfg_registered(cfg_registered), .cfg_active_low(cfg_active_low), .array_sum(array_sum),
        .prog_cmd(prog_cmd), .prog_addr(prog_addr), .prog_data(prog_data), .cell_out(cell_out),
        .cell_q(cell_q), .reset_active(reset_active), .secured(secured), .prog_rdata(prog_rdata),
        .prog_rvalid(prog_rvalid), .prog_refused(prog_refused));
    purs_board u_board (.clk_sys(clk_sys), .reset_active(reset_active), .pin_val(pin_val),
        .pin_en(pin_en), .array_sum(array_sum));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Note bit 2 means read data is not compared, bit 1 a refusal; 3'h7 leaves no note.
    task automatic cmd(input logic [2:0] c, input logic [5:0] a, input logic d,
                       input logic [2:0] n);
        @(negedge clk_sys);
        prog_cmd = c;
        prog_addr = a;
        prog_data = d;
        if (n != 3'h7) begin
            exp_q.push_back(n);
        end
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            results();
        end
    end
    // =====================================================
    // Answer monitor
    // =====================================================
    always @(posedge clk_sys) begin
        #1;
        if (prog_rvalid === 1'b1 || prog_refused === 1'b1) begin
            // An answer with no note expects a refusal carrying a one, so it always mismatches.
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 3'h3;
            check(prog_refused, e[1]);
            if (e[2] === 1'b0) begin
                check(prog_rdata, e[0]);
            end
        end
    end
    initial begin
        void'($urandom(75021));
        cfg_active_low = 10'($urandom);
        repeat (16) @(negedge clk_sys);
        check(cell_q, 10'h000);
        check(cell_out, cfg_active_low & cfg_registered);
        rst = 1'b0;
        repeat (RP - 1) @(posedge clk_sys);
        @(negedge clk_sys);
        check({reset_active, cell_q}, {1'b1, 10'h000});
        @(negedge clk_sys);
        check(reset_active, 1'b0);
        sig = {$urandom, $urandom};
        pin_en = 1'b0;
        for (int i = 0; i < 64; i++) cmd(3'h2, 6'(i), sig[i], 3'h7);
        for (int i = 0; i < 64; i++) cmd(3'h3, 6'(i), 1'b0, {2'b00, sig[i]});
        pin_en = 1'b1;
        for (int d = 0; d < 2; d++) begin
            pin_val = {10{~d[0]}};
            for (int a = 0; a < 10; a++) begin
                cmd(3'h1, 6'(a), d[0], 3'h7);
                cmd(3'h4, 6'(a), 1'b0, {2'b00, d[0]});
                check(cell_q[a], d[0]);
                check(cell_out[a], d[0] ^ cfg_active_low[a]);
            end
        end
        pin_val = 10'($urandom);
        cfg_registered = 10'h000;
        repeat (2) cmd(3'h0, 6'h00, 1'b0, 3'h7);
        check(cell_out, pin_val ^ cfg_active_low);
        cfg_registered = 10'h3FF;
        pin_val = 10'h000;
        cmd(3'h5, 6'h00, 1'b0, 3'h7);
        cmd(3'h4, 6'h03, 1'b0, 3'h6);
        cmd(3'h1, 6'h03, 1'b1, 3'h6);
        cmd(3'h3, 6'h05, 1'b0, {2'b00, sig[5]});
        check({secured, cell_q[3]}, 2'b10);
        repeat (3) cmd(3'h0, 6'h00, 1'b0, 3'h7);
        check(64'(exp_q.size()), 64'h0);
        results();
    end
endmodule

// ### verif/purs_board.sv
module purs_board (
    // Clock and device state
    input  wire logic       clk_sys,
    input  wire logic       reset_active,
    // Level that the bench asks for
    input  wire logic [9:0] pin_val,
    input  wire logic       pin_en,
    // Product-term results
    output logic      [9:0] array_sum
);
    timeunit 1ns;
    timeprecision 1ps;
    initial array_sum = 10'h000;
    // =====================================================
    // Board inputs
    // =====================================================
    // Inputs only move half a cycle ahead of an edge and freeze during the pulse.
    always @(negedge clk_sys) begin
        if (reset_active) begin
            array_sum <= array_sum;
        end else begin
            array_sum <= pin_en ? pin_val : 10'($urandom);
        end
    end
endmodule
